/* sart_pkg.sv */
// Constants, field layouts and carrier types for the static address
// and reserved multicast tables.
// Assumes a 32-bit management register port with byte addresses.
package sart_pkg;

   // ==========================================================
   // Table sizes
   localparam int SART_STATIC_DEPTH = 16;
   localparam int SART_STATIC_IW    = 4;
   localparam int SART_RSV_ADDRS    = 48;
   localparam int SART_RSV_GROUPS   = 8;
   localparam int SART_RSV_IW       = 6;
   localparam int SART_PORTS        = 5;

   // ==========================================================
   // Register offsets
   localparam logic [15:0] SART_OFF_ENTRY1 = 16'h0420;
   localparam logic [15:0] SART_OFF_ENTRY2 = 16'h0424;
   localparam logic [15:0] SART_OFF_ENTRY3 = 16'h0428;
   localparam logic [15:0] SART_OFF_ENTRY4 = 16'h042c;
   localparam logic [15:0] SART_OFF_CTRL   = 16'h0430;

   // ==========================================================
   // Entry register fields
   localparam int SART_E1_VALID = 31;
   localparam int SART_E1_SDROP = 30;
   localparam int SART_E1_DDROP = 29;
   localparam int SART_E1_PRIO  = 26;
   localparam int SART_E1_STG   = 0;
   localparam int SART_E2_OVR   = 31;
   localparam int SART_E2_FIDM  = 30;
   localparam int SART_E2_P5    = 6;
   localparam int SART_E2_P1    = 0;
   localparam int SART_E3_FID   = 16;
   localparam int SART_E3_MACHI = 0;

   // Writable bits of each entry register; the rest read zero
   localparam logic [31:0] SART_E1_WMASK = 32'hfc000007;
   localparam logic [31:0] SART_E2_WMASK = 32'hc000004f;
   localparam logic [31:0] SART_E3_WMASK = 32'h007fffff;
   localparam logic [31:0] SART_E4_WMASK = 32'hffffffff;
   localparam logic [31:0] SART_ENTRY_RST = 32'h00000000;

   // ==========================================================
   // Control register fields
   localparam int SART_CTRL_ACT = 0;
   localparam int SART_CTRL_SEL = 1;
   localparam int SART_CTRL_GO  = 7;
   localparam int SART_CTRL_IDX = 8;

   // Reserved multicast prefix; low 6 bits are the table index
   localparam logic [47:0] SART_RSV_PREFIX = 48'h0180c2000000;

   // ==========================================================
   // Carrier types
   typedef struct packed {
      logic       valid;
      logic       src_drop;
      logic       dst_drop;
      logic [2:0] prio;
      logic [2:0] spanning_tree_group;
      logic       override;
      logic       multicast_vlan_group_match;
      logic [4:0] port_mask;
      logic [6:0] vlan_group_id;
      logic [47:0] mac;
   } sart_static_entry_t;

   typedef struct packed {
      logic [47:0] destination_mac;
      logic [47:0] source_mac;
      logic [6:0]  vlan_group_id;
   } sart_lookup_req_t;

   typedef struct packed {
      logic       hit;
      logic       is_static;
      logic       dst_drop;
      logic [2:0] prio;
      logic [4:0] port_mask;
   } sart_dyn_result_t;

   typedef struct packed {
      logic       valid;
      logic       hit;
      logic       from_static;
      logic       drop;
      logic       override;
      logic [2:0] prio;
      logic [2:0] spanning_tree_group;
      logic [4:0] port_mask;
   } sart_lookup_rsp_t;

   // ==========================================================
   // Helpers
   function automatic logic [2:0] sart_rsv_group(input logic [5:0] idx);
      logic [5:0] g;
      g = idx / 6'd6;
      return g[2:0];
   endfunction : sart_rsv_group

   function automatic logic [31:0] sart_mask_word(input logic [4:0] m);
      return {25'h0000000, m[4], 2'b00, m[3:0]};
   endfunction : sart_mask_word

   function automatic logic [4:0] sart_word_mask(input logic [31:0] w);
      return {w[SART_E2_P5], w[SART_E2_P1+3:SART_E2_P1]};
   endfunction : sart_word_mask

endpackage : sart_pkg

/* sart_lookup.sv */
// Destination and source lookup against static and reserved tables.
// Assumes the dynamic table result arrives in the request's cycle.
`timescale 1ns/100ps
module sart_lookup #(
   parameter int DEPTH  = sart_pkg::SART_STATIC_DEPTH,
   parameter int GROUPS = sart_pkg::SART_RSV_GROUPS
) (
   input  wire logic                                   i_clk,
   input  wire logic                                   i_reset_n,
   input  wire logic                                   i_req_valid,
   input  wire sart_pkg::sart_lookup_req_t             i_req,
   input  wire sart_pkg::sart_dyn_result_t             i_dyn,
   input  wire sart_pkg::sart_static_entry_t [DEPTH-1:0] i_table,
   input  wire logic [GROUPS-1:0][4:0]                 i_rsv_mask,
   output sart_pkg::sart_lookup_rsp_t                  o_rsp
);
   import sart_pkg::*;

   sart_lookup_rsp_t next_rsp;
   sart_static_entry_t hit_e;
   logic st_hit;
   logic src_hit;
   logic is_mcast;
   logic rsv_hit;

   assign is_mcast = i_req.destination_mac[40];
   assign rsv_hit  = is_mcast && i_req.destination_mac[47:6] ==
                     SART_RSV_PREFIX[47:6] &&
                     i_req.destination_mac[5:0] < 6'(SART_RSV_ADDRS);

   always_comb begin
      st_hit  = 1'b0;
      src_hit = 1'b0;
      hit_e   = '0;
      for (int i = DEPTH - 1; i >= 0; i--) begin
         if (i_table[i].valid &&
             i_table[i].mac == i_req.destination_mac &&
             (!(is_mcast && i_table[i].multicast_vlan_group_match) ||
              i_table[i].vlan_group_id == i_req.vlan_group_id)) begin
            st_hit = 1'b1;
            hit_e  = i_table[i];
         end
         if (i_table[i].valid && i_table[i].src_drop &&
             i_table[i].mac == i_req.source_mac) begin
            src_hit = 1'b1;
         end
      end
   end

   always_comb begin
      next_rsp       = '0;
      next_rsp.valid = i_req_valid;
      if (rsv_hit) begin
         next_rsp.hit         = 1'b1;
         next_rsp.from_static = 1'b1;
         next_rsp.port_mask   =
            i_rsv_mask[sart_rsv_group(i_req.destination_mac[5:0])];
      end else if (st_hit) begin
         next_rsp.hit                 = 1'b1;
         next_rsp.from_static         = 1'b1;
         next_rsp.drop                = hit_e.dst_drop;
         next_rsp.override            = hit_e.override;
         next_rsp.prio                = hit_e.prio;
         next_rsp.spanning_tree_group = hit_e.spanning_tree_group;
         next_rsp.port_mask           = hit_e.port_mask;
      end else if (i_dyn.hit) begin
         next_rsp.hit         = 1'b1;
         next_rsp.from_static = i_dyn.is_static;
         next_rsp.drop        = i_dyn.dst_drop;
         next_rsp.prio        = i_dyn.prio;
         next_rsp.port_mask   = i_dyn.port_mask;
      end
      if (src_hit) begin
         next_rsp.drop = 1'b1;
      end
      if (!i_req_valid) begin
         next_rsp = '0;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_rsp <= '0;
      end else begin
         o_rsp <= next_rsp;
      end
   end

endmodule : sart_lookup

/* sart_tables.sv */
// Static address table and reserved multicast table with indirect
// register access, plus the lookup that uses them.
// Assumes a single-cycle register strobe port on the core clock.
`timescale 1ns/100ps

// Summary of operation
// - sixteen host programmed static entries
// - static entries never age out
// - every lookup searches all tables
// - static results beat dynamic results
// - four-bit index picks static entry
// - operation bit zero writes, one reads
// - select bit zero static, one multicast
// - go starts access, self clears
// - read result in data registers
// - 48 multicast addresses by low bits share 8 group masks
// - mask write changes whole group
// - six-bit index, second register mask
// - first register top bit valid
// - bit 30 drops source matches
// - bit 29 drops destination matches
// - priority and spanning tree fields
// - override bit bypasses port state
// - multicast match may compare group
// - port mask bits, 5:4 reserved
// - third/fourth registers hold group, MAC
module sart_tables #(
   parameter int DEPTH  = sart_pkg::SART_STATIC_DEPTH,
   parameter int GROUPS = sart_pkg::SART_RSV_GROUPS
) (
   input  wire logic                       i_clk,
   input  wire logic                       i_reset_n,
   input  wire logic [15:0]                i_reg_addr,
   input  wire logic                       i_reg_wr,
   input  wire logic                       i_reg_rd,
   input  wire logic [31:0]                i_reg_wdata,
   output logic [31:0]                     o_reg_rdata,
   output logic                            o_reg_rvalid,
   input  wire logic                       i_lookup_valid,
   input  wire sart_pkg::sart_lookup_req_t i_lookup_req,
   input  wire sart_pkg::sart_dyn_result_t i_dyn_result,
   output sart_pkg::sart_lookup_rsp_t      o_lookup_rsp,
   output logic                            o_busy
);
   import sart_pkg::*;

   typedef enum {SART_IDLE, SART_ACCESS} sart_state_t;

   // ==========================================================
   // Storage
   // static table storage
   sart_static_entry_t [DEPTH-1:0] static_tbl;
   logic [GROUPS-1:0][4:0]         rsv_mask;
   logic [31:0]                    entry_reg [4];
   sart_state_t                    state;
   logic                           ctl_go;
   logic                           ctl_act;
   logic                           ctl_sel;
   logic [5:0]                     ctl_idx;

   // ==========================================================
   // Decode
   logic        aligned;
   logic        hit_entry;
   logic        hit_ctrl;
   logic [1:0]  entry_sel;
   logic        wr_ok;
   logic        wr_entry;
   logic        wr_ctrl;
   logic        go_req;
   logic [31:0] ctrl_word;
   logic [31:0] rd_word;
   logic [31:0] wr_mask;
   logic [3:0]  st_idx;
   logic [2:0]  grp_idx;
   logic        rsv_idx_ok;
   logic        do_access;
   sart_static_entry_t st_rd;
   sart_static_entry_t st_wr;
   logic [31:0] st_mask_word;
   logic [31:0] rsv_mask_word;

   assign aligned   = i_reg_addr[1:0] == 2'b00;
   assign hit_entry = aligned &&
                      i_reg_addr[15:4] == SART_OFF_ENTRY1[15:4];
   assign hit_ctrl  = i_reg_addr == SART_OFF_CTRL;
   assign entry_sel = i_reg_addr[3:2];
   // Writes while busy are dropped so an access sees stable data
   assign wr_ok     = i_reg_wr && state == SART_IDLE;
   assign wr_entry  = wr_ok && hit_entry;
   assign wr_ctrl   = wr_ok && hit_ctrl;
   assign go_req    = wr_ctrl && i_reg_wdata[SART_CTRL_GO];
   assign do_access = state == SART_ACCESS;

   assign wr_mask = entry_sel == 2'd0 ? SART_E1_WMASK :
                    entry_sel == 2'd1 ? SART_E2_WMASK :
                    entry_sel == 2'd2 ? SART_E3_WMASK :
                                        SART_E4_WMASK;

   assign ctrl_word = {18'h00000, ctl_idx, ctl_go, 5'h00,
                       ctl_sel, ctl_act};

   assign rd_word = hit_entry ? entry_reg[entry_sel] :
                    hit_ctrl  ? ctrl_word :
                                32'h00000000;

   assign st_idx     = ctl_idx[SART_STATIC_IW-1:0];
   assign grp_idx    = sart_rsv_group(ctl_idx);
   assign rsv_idx_ok = ctl_idx < 6'(SART_RSV_ADDRS);
   assign st_rd      = static_tbl[st_idx];
   assign st_mask_word  = sart_mask_word(st_rd.port_mask);
   // Out-of-range index reads back an empty mask
   assign rsv_mask_word = rsv_idx_ok ? sart_mask_word(rsv_mask[grp_idx]) :
                                       32'h00000000;

   assign st_wr.valid    = entry_reg[0][SART_E1_VALID];
   assign st_wr.src_drop = entry_reg[0][SART_E1_SDROP];
   assign st_wr.dst_drop = entry_reg[0][SART_E1_DDROP];
   assign st_wr.prio     = entry_reg[0][SART_E1_PRIO+2:SART_E1_PRIO];
   assign st_wr.spanning_tree_group =
                           entry_reg[0][SART_E1_STG+2:SART_E1_STG];
   assign st_wr.override = entry_reg[1][SART_E2_OVR];
   assign st_wr.multicast_vlan_group_match =
                           entry_reg[1][SART_E2_FIDM];
   assign st_wr.port_mask = sart_word_mask(entry_reg[1]);
   assign st_wr.vlan_group_id = entry_reg[2][SART_E3_FID+6:SART_E3_FID];
   assign st_wr.mac = {entry_reg[2][SART_E3_MACHI+15:SART_E3_MACHI],
                       entry_reg[3]};

   // ==========================================================
   // Access sequencer
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state <= SART_IDLE;
      end else begin
         case (state)
            SART_IDLE: begin
               if (go_req) begin
                  state <= SART_ACCESS;
               end
            end
            SART_ACCESS: begin
               state <= SART_IDLE;
            end
            default: begin
               state <= SART_IDLE;
            end
         endcase
      end
   end

   // Control register
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ctl_go  <= 1'b0;
         ctl_act <= 1'b0;
         ctl_sel <= 1'b0;
         ctl_idx <= 6'h00;
      end else if (wr_ctrl) begin
         ctl_act <= i_reg_wdata[SART_CTRL_ACT];
         ctl_sel <= i_reg_wdata[SART_CTRL_SEL];
         ctl_idx <= i_reg_wdata[SART_CTRL_IDX+5:SART_CTRL_IDX];
         ctl_go  <= i_reg_wdata[SART_CTRL_GO];
      end else if (do_access) begin
         ctl_go <= 1'b0;
      end
   end

   // ==========================================================
   // Entry data registers
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         for (int i = 0; i < 4; i++) begin
            entry_reg[i] <= SART_ENTRY_RST;
         end
      end else if (wr_entry) begin
         entry_reg[entry_sel] <= i_reg_wdata & wr_mask;
      end else if (do_access && ctl_act && !ctl_sel) begin
         entry_reg[0] <= {st_rd.valid, st_rd.src_drop, st_rd.dst_drop,
                          st_rd.prio, 23'h000000,
                          st_rd.spanning_tree_group};
         entry_reg[1] <= {st_rd.override,
                          st_rd.multicast_vlan_group_match, 23'h000000,
                          st_mask_word[6:0]};
         entry_reg[2] <= {9'h000, st_rd.vlan_group_id, st_rd.mac[47:32]};
         entry_reg[3] <= st_rd.mac[31:0];
      end else if (do_access && ctl_act && ctl_sel) begin
         entry_reg[1] <= {entry_reg[1][31:30], 23'h000000,
                          rsv_mask_word[6:0]};
      end
   end

   // ==========================================================
   // Table writes
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         static_tbl <= '0;
         rsv_mask   <= '0;
      end else if (do_access && !ctl_act) begin
         // entries change only by host write
         if (!ctl_sel) begin
            static_tbl[st_idx] <= st_wr;
         end else if (rsv_idx_ok) begin
            rsv_mask[grp_idx] <= sart_word_mask(entry_reg[1]);
         end
      end
   end

   // ==========================================================
   // Register read port
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_reg_rdata  <= 32'h00000000;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd;
         if (i_reg_rd) begin
            o_reg_rdata <= rd_word;
         end
      end
   end

   assign o_busy = ctl_go;

   // ==========================================================
   // Lookup
   sart_lookup #(
      .DEPTH  (DEPTH),
      .GROUPS (GROUPS)
   ) u_lookup (
      .i_clk       (i_clk),
      .i_reset_n   (i_reset_n),
      .i_req_valid (i_lookup_valid),
      .i_req       (i_lookup_req),
      .i_dyn       (i_dyn_result),
      .i_table     (static_tbl),
      .i_rsv_mask  (rsv_mask),
      .o_rsp       (o_lookup_rsp)
   );

endmodule : sart_tables

/* sart_tables_properties.sv */
// Port checker for the static and reserved multicast table block.
// Bound to sart_tables; sees only that module's ports.
`timescale 1ns/100ps
module sart_chk
   import sart_pkg::*;
#(
   parameter int DEPTH  = 16,
   parameter int GROUPS = 8
) (
   input wire logic             i_clk,
   input wire logic             i_reset_n,
   input wire logic [15:0]      i_reg_addr,
   input wire logic             i_reg_wr,
   input wire logic             i_reg_rd,
   input wire logic [31:0]      i_reg_wdata,
   input wire logic [31:0]      o_reg_rdata,
   input wire logic             o_reg_rvalid,
   input wire logic             i_lookup_valid,
   input wire sart_lookup_req_t i_lookup_req,
   input wire sart_dyn_result_t i_dyn_result,
   input wire sart_lookup_rsp_t o_lookup_rsp,
   input wire logic             o_busy
);
   // ====
   // Decode
   wire go_wr = i_reg_wr && i_reg_addr == SART_OFF_CTRL
                && i_reg_wdata[SART_CTRL_GO] && !o_busy;
   wire rsv_da = i_lookup_req.destination_mac[47:8]
                 == SART_RSV_PREFIX[47:8];

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);

   sequence s_go;
      go_wr;
   endsequence
   sequence s_pulse;
      o_busy ##1 !o_busy;
   endsequence

   // ====
   // Properties
   chk_go_busy_pulse: assert property (s_go |=> s_pulse)
      else $error("go write gave no single busy cycle");
   chk_busy_cause: assert property (!o_busy && !go_wr |=> !o_busy)
      else $error("busy rose without a go write");
   chk_rd_answer: assert property (i_reg_rd |=> o_reg_rvalid)
      else $error("read got no valid pulse");
   chk_rvalid_cause: assert property (!i_reg_rd |=> !o_reg_rvalid)
      else $error("valid pulse without a read");
   chk_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
      else $error("read data moved without a read");
   chk_e1_reserved: assert property (o_reg_rvalid
      && $past(i_reg_addr) == SART_OFF_ENTRY1 |-> o_reg_rdata[25:3] == 0)
      else $error("entry1 reserved bits not zero");
   chk_e2_reserved: assert property (o_reg_rvalid
      && $past(i_reg_addr) == SART_OFF_ENTRY2
      |-> o_reg_rdata[29:7] == 0 && o_reg_rdata[5:4] == 0)
      else $error("entry2 reserved bits not zero");
   chk_e3_reserved: assert property (o_reg_rvalid
      && $past(i_reg_addr) == SART_OFF_ENTRY3 |-> o_reg_rdata[31:23] == 0)
      else $error("entry3 reserved bits not zero");
   chk_lookup_lat: assert property (i_lookup_valid |=> o_lookup_rsp.valid)
      else $error("lookup answer missing");
   chk_rsp_idle: assert property (!i_lookup_valid |=> o_lookup_rsp == '0)
      else $error("lookup answer without request");
   chk_static_wins: assert property (i_lookup_valid && !rsv_da
      && i_dyn_result.hit && i_dyn_result.is_static
      |=> o_lookup_rsp.from_static)
      else $error("static dynamic hit not reported static");
endmodule : sart_chk

bind sart_tables sart_chk #(.DEPTH(DEPTH), .GROUPS(GROUPS)) u_chk (
   .i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr),
   .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
   .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
   .i_lookup_valid(i_lookup_valid), .i_lookup_req(i_lookup_req),
   .i_dyn_result(i_dyn_result), .o_lookup_rsp(o_lookup_rsp),
   .o_busy(o_busy));

/* tb_top.sv */
// Self-checking bench for the static and reserved multicast tables.
// Drives the register strobe port and the lookup port directly.
`timescale 1ns/100ps
module tb_top;
   import sart_pkg::*;
   logic             i_clk          = 1'b0;
   logic             i_reset_n      = 1'b0;
   logic [15:0]      i_reg_addr     = 16'h0000;
   logic             i_reg_wr       = 1'b0;
   logic             i_reg_rd       = 1'b0;
   logic [31:0]      i_reg_wdata    = 32'h00000000;
   logic [31:0]      o_reg_rdata;
   logic             o_reg_rvalid;
   logic             i_lookup_valid = 1'b0;
   sart_lookup_req_t i_lookup_req   = '0;
   sart_dyn_result_t i_dyn_result   = '0;
   sart_lookup_rsp_t o_lookup_rsp;
   logic             o_busy;
   int               n_fail         = 0;
   int               compares       = 0;
   // Writable bits of entry registers 1 to 4
   logic [31:0]      wm [4] = '{32'hfc000007, 32'hc000004f,
                               32'h007fffff, 32'hffffffff};

   always #12.5 i_clk = ~i_clk;

   sart_tables dut (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_reg_addr(i_reg_addr),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
      .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
      .i_lookup_valid(i_lookup_valid), .i_lookup_req(i_lookup_req),
      .i_dyn_result(i_dyn_result), .o_lookup_rsp(o_lookup_rsp),
      .o_busy(o_busy));

   // ====
   // Bus and compare tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_reg_wr    <= 1'b1;
      i_reg_addr  <= a;
      i_reg_wdata <= d;
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      @(posedge i_clk);
      i_reg_rd   <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_clk);
      i_reg_rd <= 1'b0;
      #1;
      chk({31'h0, o_reg_rvalid}, 32'h1);
      chk(o_reg_rdata, e);
   endtask : rd

   // Exactly one busy cycle per access
   task automatic go(input logic [31:0] c);
      wr(SART_OFF_CTRL, c | 32'h00000080);
      #1;
      chk({31'h0, o_busy}, 32'h1);
      // host holds off until busy clears
      @(posedge i_clk);
      #1;
      chk({31'h0, o_busy}, 32'h0);
   endtask : go

   task automatic lk(input logic [47:0] da, input logic [47:0] sa,
                     input logic [6:0] vg, input sart_dyn_result_t dy,
                     input logic [15:0] e, input logic [15:0] m);
      @(posedge i_clk);
      i_lookup_valid <= 1'b1;
      i_lookup_req   <= {da, sa, vg};
      i_dyn_result   <= dy;
      @(posedge i_clk);
      i_lookup_valid <= 1'b0;
      #1;
      chk({16'h0, o_lookup_rsp & m}, {16'h0, e & m});
   endtask : lk

   // ====
   // Scenarios
   task automatic t_reset;
      // Last pass hits the unmapped word after control
      for (int i = 0; i < 6; i++) rd(16'h0420 + 16'(4 * i), 32'h0);
      $display("test reset done");
   endtask : t_reset

   task automatic t_static;
      for (int i = 0; i < 4; i++) wr(16'h0420 + 16'(4 * i), '1);
      for (int i = 0; i < 4; i++) rd(16'h0420 + 16'(4 * i), wm[i]);
      go(32'h00000f00);
      for (int i = 0; i < 4; i++) wr(16'h0420 + 16'(4 * i), 32'h0);
      go(32'h00000e01);
      for (int i = 0; i < 4; i++) rd(16'h0420 + 16'(4 * i), 32'h0);
      go(32'h00000f01);
      for (int i = 0; i < 4; i++) rd(16'h0420 + 16'(4 * i), wm[i]);
      rd(SART_OFF_CTRL, 32'h00000f01);
      $display("test static done");
   endtask : t_static

   task automatic t_mcast;
      wr(SART_OFF_ENTRY2, 32'h0000004b);
      go(32'h00000702);
      wr(SART_OFF_ENTRY2, 32'h0);
      go(32'h00000b03);
      rd(SART_OFF_ENTRY2, 32'h0000004b);
      go(32'h00000c03);
      rd(SART_OFF_ENTRY2, 32'h0);
      // Index 48 is past the table: write ignored, read gives no mask
      wr(SART_OFF_ENTRY2, 32'h0000004f);
      go(32'h00003002);
      go(32'h00003003);
      rd(SART_OFF_ENTRY2, 32'h0);
      go(32'h00000003);
      rd(SART_OFF_ENTRY2, 32'h0);
      $display("test mcast done");
   endtask : t_mcast

   task automatic t_lookup;
      // Entry 15 is all ones: group match needed, drops destination
      lk('1, 48'h0, 7'h7f, 11'h645, 16'hffff, 16'hffff);
      lk('1, 48'h0, 7'h00, 11'h445, 16'hc205, 16'hffff);
      lk(48'h1, '1, 7'h00, 11'h000, 16'h9000, 16'hffff);
      for (int i = 6; i < 12; i++)
         lk({40'h0180c20000, 8'(i)}, 48'h0, 7'h0, 11'h445,
            16'h801b, 16'h801f);
      lk(48'h0180c200000c, 48'h0, 7'h0, 11'h0, 16'h8000, 16'h801f);
      $display("test lookup done");
   endtask : t_lookup

   task automatic tally_and_finish;
      $display("compares %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : tally_and_finish

   // ====
   // Main sequence and watchdog
   initial begin
      repeat (2) @(posedge i_clk);
      i_reset_n <= 1'b1;
      t_reset;
      t_static;
      t_mcast;
      t_lookup;
      tally_and_finish;
   end

   // Run needs about 120 cycles
   initial begin
      #(3000 * 25);
      n_fail++;
      tally_and_finish;
   end
endmodule : tb_top
